// ### dmc_regs.svh
// constants for the mode-register configuration block
// assumes the includer works on a single 125 MHz clock
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_BANK_MR0 3'h0
`define DMC_BANK_MR1 3'h1
`define DMC_BL_FIXED8 2'h0
`define DMC_BL_OTF 2'h1
`define DMC_BL_FIXED4 2'h2
`define DMC_MR0_BT 3
`define DMC_MR0_DLLRST 8
`define DMC_MR0_PPD 12
`define DMC_MR1_DLLDIS 0
`define DMC_MR1_WLEV 7
`define DMC_MR1_QOFF 12
`define DMC_CHOP_PULL 4'h2
`define DMC_DLL_RST_CYC 4'h4
`endif

// ### dmc_pkg.sv
// types shared by the mode-register configuration block
package dmc_pkg;
	typedef enum logic [1:0] {
		dmc_idle,
		dmc_read,
		dmc_write
	} dmc_burst_t;
endpackage

// ### dmc_order.sv
// burst word order for a given starting column and beat
// assumes purely combinational use by the burst engine
`timescale 1ns/10ps
`include "dmc_regs.svh"
module dmc_order (
	input wire logic [2:0] start_col,
	input wire logic [2:0] beat,
	input wire logic interleave,
	input wire logic is_write,
	output logic [2:0] word
);
	wire [2:0] seq_word;
	wire [2:0] ilv_word;
	wire [2:0] wr_word;
	// low bits wrap in each half; bit 2 flips for the second half
	assign seq_word = {start_col[2] ^ beat[2],
		2'(start_col[1:0] + beat[1:0])};
	assign ilv_word = start_col ^ beat;
	// writes only honour bit 2 of the start column
	assign wr_word = {start_col[2] ^ beat[2], beat[1:0]};
	assign word = is_write ? wr_word
		: (interleave ? ilv_word : seq_word);
endmodule // dmc_order

// ### dmc_dll.sv
// dll state: reset pulse, self-refresh and power-down handling
// assumes commands arrive already decoded on the device clock
`timescale 1ns/10ps
`include "dmc_regs.svh"
module dmc_dll (
	input wire logic clk,
	input wire logic rst,
	input wire logic dll_disable,
	input wire logic dll_reset_req,
	input wire logic self_refresh,
	input wire logic pd_precharge,
	input wire logic pd_fast_exit,
	output logic dll_running,
	output logic dll_reset_done
);
	logic [3:0] rst_cnt;
	wire busy;
	assign busy = rst_cnt != 4'h0;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_cnt <= 4'h0;
			dll_reset_done <= 1'b0;
		end else begin
			dll_reset_done <= busy && rst_cnt == 4'h1;
			if (dll_reset_req)
				rst_cnt <= `DMC_DLL_RST_CYC;
			else if (busy)
				rst_cnt <= rst_cnt - 4'h1;
		end
	end
	// slow-exit freezes the dll in precharge power-down
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dll_running <= 1'b0;
		else
			dll_running <= !dll_disable && !self_refresh
				&& !(pd_precharge && !pd_fast_exit);
	end
endmodule // dmc_dll

// ### dmc_mode_config.sv
// mode registers 0 and 1 plus the burst engine they steer
// assumes a decoded command bus on clk; dq pins resolved outside
`timescale 1ns/10ps
`include "dmc_regs.svh"
module dmc_mode_config (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_mrs,
	input wire logic cmd_read,
	input wire logic cmd_write,
	input wire logic [2:0] bank,
	input wire logic [15:0] addr,
	input wire logic self_refresh,
	input wire logic pd_precharge,
	output logic [15:0] burst_latency_config,
	output logic [15:0] dll_drive_termination_config,
	output logic [3:0] cas_latency,
	output logic [1:0] additive_latency,
	output logic [1:0] drive_strength,
	output logic [2:0] write_recovery,
	output logic [2:0] word_index,
	output logic dq_oe,
	output logic dq_capture,
	output logic write_start,
	output logic dll_running,
	output logic odt_wr_apply
);
	dmc_pkg::dmc_burst_t state;
	dmc_pkg::dmc_burst_t next_state;
	logic [3:0] beat;
	logic [2:0] start_col;
	logic chop;
	logic [4:0] hold_cnt;
	logic hold_rd;
	logic hold_wr;
	logic [2:0] hold_col;
	logic hold_chop;
	logic dll_rst_req;
	logic dll_rst_done;
	logic dll_run_int;
	wire wr_mr0;
	wire wr_mr1;
	wire [1:0] bl_mode;
	wire cmd_chop;
	wire [4:0] al_cycles;
	wire [2:0] order_word;
	wire burst_end;
	wire go;
	// bank decode for mode register writes
	assign wr_mr0 = cmd_mrs && bank == `DMC_BANK_MR0;
	assign wr_mr1 = cmd_mrs && bank == `DMC_BANK_MR1;
	assign bl_mode = burst_latency_config[1:0];
	// on-the-fly: A12 low on the command asks for a chop
	assign cmd_chop = bl_mode == `DMC_BL_FIXED4
		|| (bl_mode == `DMC_BL_OTF && !addr[12]);
	function automatic logic [4:0] al_of(input logic [1:0] al,
		input logic [3:0] cl);
		case (al)
			2'h1: al_of = 5'(cl) - 5'h1;
			2'h2: al_of = 5'(cl) - 5'h2;
			default: al_of = 5'h0;
		endcase
	endfunction
	assign al_cycles = al_of(additive_latency, cas_latency);
	assign go = hold_cnt == 5'h0 && (hold_rd || hold_wr);
	assign burst_end = beat == (chop ? 4'h3 : 4'h7);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			burst_latency_config <= 16'h0000;
			dll_drive_termination_config <= 16'h0000;
		end else begin
			if (wr_mr0)
				burst_latency_config <= addr & ~(16'h1 << `DMC_MR0_DLLRST);
			if (wr_mr1)
				dll_drive_termination_config <= addr;
		end
	end
	// the reset bit reads back cleared; the pulse drives the dll
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			dll_rst_req <= 1'b0;
		else
			dll_rst_req <= wr_mr0 && addr[`DMC_MR0_DLLRST];
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cas_latency <= 4'h0;
			additive_latency <= 2'h0;
			drive_strength <= 2'h0;
			write_recovery <= 3'h0;
		end else begin
			cas_latency <= {burst_latency_config[6:4],
				burst_latency_config[2]};
			additive_latency <= dll_drive_termination_config[4:3];
			drive_strength <= {dll_drive_termination_config[5],
				dll_drive_termination_config[1]};
			write_recovery <= burst_latency_config[11:9];
		end
	end
	// command held for the additive latency before it runs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_cnt <= 5'h0;
			hold_rd <= 1'b0;
			hold_wr <= 1'b0;
			hold_col <= 3'h0;
			hold_chop <= 1'b0;
		end else if (cmd_read || cmd_write) begin
			hold_cnt <= al_cycles;
			hold_rd <= cmd_read;
			hold_wr <= cmd_write;
			hold_col <= addr[2:0];
			hold_chop <= cmd_chop;
		end else if (hold_cnt != 5'h0) begin
			hold_cnt <= hold_cnt - 5'h1;
		end else begin
			hold_rd <= 1'b0;
			hold_wr <= 1'b0;
		end
	end
	always_comb begin
		next_state = state;
		case (state)
			dmc_pkg::dmc_idle: begin
				if (go && hold_rd)
					next_state = dmc_pkg::dmc_read;
				else if (go && hold_wr)
					next_state = dmc_pkg::dmc_write;
			end
			default: begin
				if (burst_end)
					next_state = dmc_pkg::dmc_idle;
			end
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= dmc_pkg::dmc_idle;
			beat <= 4'h0;
			start_col <= 3'h0;
			chop <= 1'b0;
		end else begin
			state <= next_state;
			if (state == dmc_pkg::dmc_idle) begin
				beat <= 4'h0;
				start_col <= hold_col;
				chop <= hold_chop;
			end else begin
				beat <= beat + 4'h1;
			end
		end
	end
	// full writes always run from word zero, whatever the column
	wire [2:0] order_col;
	assign order_col = (state == dmc_pkg::dmc_write && !chop)
		? 3'h0 : start_col;
	dmc_order u_order (
		.start_col(order_col),
		.beat(beat[2:0]),
		.interleave(burst_latency_config[`DMC_MR0_BT]),
		.is_write(state == dmc_pkg::dmc_write),
		.word(order_word)
	);
	dmc_dll u_dll (
		.clk(clk),
		.rst(rst),
		.dll_disable(dll_drive_termination_config[`DMC_MR1_DLLDIS]),
		.dll_reset_req(dll_rst_req),
		.self_refresh(self_refresh),
		.pd_precharge(pd_precharge),
		.pd_fast_exit(burst_latency_config[`DMC_MR0_PPD]),
		.dll_running(dll_run_int),
		.dll_reset_done(dll_rst_done)
	);
	// chopped bursts stop after four, so the last four slots stay hi-z
	wire rd_active;
	assign rd_active = state == dmc_pkg::dmc_read;
	// fixed chop starts the internal write two clocks early;
	// on-the-fly chop keeps the full-burst reference point
	wire [3:0] wr_start_beat;
	assign wr_start_beat = (chop && bl_mode == `DMC_BL_FIXED4)
		? 4'h7 - `DMC_CHOP_PULL : 4'h7;
	// the write reference counts eight slots even when the burst is chopped
	logic [3:0] wr_pos;
	logic wr_pos_run;
	wire wr_begin;
	assign wr_begin = state == dmc_pkg::dmc_idle
		&& next_state == dmc_pkg::dmc_write;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pos <= 4'h0;
			wr_pos_run <= 1'b0;
		end else if (wr_begin) begin
			wr_pos <= 4'h0;
			wr_pos_run <= 1'b1;
		end else if (wr_pos_run) begin
			wr_pos <= wr_pos + 4'h1;
			wr_pos_run <= wr_pos != 4'h7;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_index <= 3'h0;
			dq_oe <= 1'b0;
			dq_capture <= 1'b0;
			write_start <= 1'b0;
			dll_running <= 1'b0;
			odt_wr_apply <= 1'b0;
		end else begin
			word_index <= order_word;
			dq_oe <= rd_active
				&& !dll_drive_termination_config[`DMC_MR1_QOFF];
			dq_capture <= state == dmc_pkg::dmc_write;
			write_start <= wr_pos_run
				&& wr_pos == wr_start_beat;
			dll_running <= dll_run_int && !dll_rst_req;
			// write termination does not depend on nominal setting
			odt_wr_apply <= state == dmc_pkg::dmc_write;
		end
	end
	wire unused_done;
	assign unused_done = dll_rst_done;
	AST_QOFF: assert property (@(posedge clk) disable iff (rst)
		dll_drive_termination_config[12] |=> !dq_oe)
		else $error("outputs driven while disabled");
	AST_DLLRST_CLEAR: assert property (@(posedge clk) disable iff (rst)
		wr_mr0 |=> !burst_latency_config[8])
		else $error("dll reset bit stuck");
	AST_CHOP_LEN: assert property (@(posedge clk) disable iff (rst)
		(rd_active && chop && beat == 4'h3) |=> state == dmc_pkg::dmc_idle)
		else $error("chop burst too long");
	AST_FULL_LEN: assert property (@(posedge clk) disable iff (rst)
		(rd_active && !chop && beat == 4'h3) |=> rd_active)
		else $error("full burst ended early");
	AST_ILV: assert property (@(posedge clk) disable iff (rst)
		(rd_active && burst_latency_config[3])
		|=> word_index == (start_col ^ $past(beat[2:0])))
		else $error("interleave order wrong");
	AST_CL: assert property (@(posedge clk) disable iff (rst)
		wr_mr0 |=> ##1 cas_latency == {$past(addr[6:4], 2), $past(addr[2], 2)})
		else $error("cas latency not taken");
	AST_DRV: assert property (@(posedge clk) disable iff (rst)
		wr_mr1 |=> ##1 drive_strength == {$past(addr[5], 2), $past(addr[1], 2)})
		else $error("drive strength not taken");
	AST_SR: assert property (@(posedge clk) disable iff (rst)
		self_refresh |=> ##1 !dll_running)
		else $error("dll runs in self-refresh");
	AST_WR_ORDER: assert property (@(posedge clk) disable iff (rst)
		(state == dmc_pkg::dmc_write)
		|=> word_index[1:0] == $past(beat[1:0]))
		else $error("write order wrong");
	COV_READ8: cover property (@(posedge clk) rd_active && !chop && beat == 4'h7);
	COV_CHOP: cover property (@(posedge clk) rd_active && chop && beat == 4'h3);
	COV_WRITE: cover property (@(posedge clk) write_start);
endmodule // dmc_mode_config

// ### dmc_ctrl_model.sv
// controller-side model driving decoded commands into the block
// assumes the bench calls issue() from one process at a time
`timescale 1ns/10ps
module dmc_ctrl_model (
	input wire logic clk,
	output logic cmd_mrs,
	output logic cmd_read,
	output logic cmd_write,
	output logic [2:0] bank,
	output logic [15:0] addr
);
	initial begin
		{cmd_mrs, cmd_read, cmd_write} = 3'h0;
		bank = 3'h0;
		addr = 16'h0;
	end
	// c is {mrs, read, write}; bank 0 = reg0 1 = reg1
	task automatic issue(input logic [2:0] c, input logic [2:0] b,
		input logic [15:0] a);
		@(posedge clk);
		{cmd_mrs, cmd_read, cmd_write} <= c;
		bank <= b;
		addr <= a;
		@(posedge clk);
		{cmd_mrs, cmd_read, cmd_write} <= 3'h0;
		// released lines flip so a stale value is never mistaken for valid
		bank <= ~b;
		addr <= ~a;
	endtask
endmodule // dmc_ctrl_model

// ### ddr3_mode_burst_dll_config_tb.sv
// self-checking bench for the mode-register configuration block
// assumes the controller model is the only driver of the command pins
`timescale 1ns/10ps
`include "dmc_regs.svh"
module ddr3_mode_burst_dll_config_tb;
	typedef struct packed {
		logic [15:0] mr0;
		logic [2:0] col;
		logic wr;
		logic bc;
		logic [3:0] beats;
	} dmc_row_t;
	logic clk, rst, self_refresh, pd_precharge, cmd_mrs, cmd_read, cmd_write;
	logic dq_oe, dq_capture, write_start, dll_running, odt_wr_apply;
	logic [2:0] bank, write_recovery, word_index;
	logic [15:0] addr, burst_latency_config, dll_drive_termination_config;
	logic [3:0] cas_latency;
	logic [1:0] additive_latency, drive_strength;
	int n_mismatch = 0, compares = 0, n, ws;
	dmc_row_t r;
	dmc_row_t rows [8] = '{
		'{16'h0000, 3'h5, 1'b0, 1'b1, 4'h8}, '{16'h0008, 3'h5, 1'b0, 1'b1, 4'h8},
		'{16'h0002, 3'h6, 1'b0, 1'b1, 4'h4}, '{16'h0009, 3'h3, 1'b0, 1'b0, 4'h4},
		'{16'h0009, 3'h7, 1'b0, 1'b1, 4'h8}, '{16'h0000, 3'h5, 1'b1, 1'b1, 4'h8},
		'{16'h0002, 3'h6, 1'b1, 1'b1, 4'h4}, '{16'h0001, 3'h3, 1'b1, 1'b0, 4'h4}};
	dmc_ctrl_model i_ctrl (.clk(clk), .cmd_mrs(cmd_mrs), .cmd_read(cmd_read),
		.cmd_write(cmd_write), .bank(bank), .addr(addr));
	dmc_mode_config i_dut (.clk(clk), .rst(rst), .cmd_mrs(cmd_mrs),
		.cmd_read(cmd_read), .cmd_write(cmd_write), .bank(bank), .addr(addr),
		.self_refresh(self_refresh), .pd_precharge(pd_precharge),
		.burst_latency_config(burst_latency_config),
		.dll_drive_termination_config(dll_drive_termination_config),
		.cas_latency(cas_latency), .additive_latency(additive_latency),
		.drive_strength(drive_strength), .write_recovery(write_recovery),
		.word_index(word_index), .dq_oe(dq_oe), .dq_capture(dq_capture),
		.write_start(write_start), .dll_running(dll_running),
		.odt_wr_apply(odt_wr_apply));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// expected word for beat k, worked out from the burst order tables
	function automatic logic [2:0] ew(input logic [2:0] c, k,
		input logic il, wr, ch);
		if (wr)
			ew = ch ? {c[2], k[1:0]} : k;
		else if (il)
			ew = c ^ k;
		else
			ew = {c[2] ^ k[2], c[1:0] + k[1:0]};
	endfunction
	task automatic check(input string nm, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// bounded wait for the first beat; 20 means the burst never showed
	task automatic wait_burst(input logic wr, output int cnt);
		cnt = 0;
		do begin
			tick(1);
			cnt++;
		end while (cnt < 20 && (wr ? dq_capture : dq_oe) !== 1'b1);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		self_refresh = 1'b0;
		pd_precharge = 1'b0;
		tick(16);
		rst <= 1'b0;
		tick(1);
		check("reg0", 16'h0, burst_latency_config);
		check("dq_oe", 16'h0, dq_oe);
		$display("test reset done");
		// dll on, termination bits zero then dll reset
		// no write leveling no nominal odt
		// reg2 left alone so dynamic odt stays off
		i_ctrl.issue(3'h4, `DMC_BANK_MR1, 16'h0020);
		i_ctrl.issue(3'h4, `DMC_BANK_MR0, 16'h1b34);
		tick(12); // lock wait before any read
		check("reg0", 16'h1a34, burst_latency_config);
		check("cl", 16'h7, cas_latency);
		check("wr", 16'h5, write_recovery);
		check("drv", 16'h2, drive_strength);
		check("reg1", 16'h0020, dll_drive_termination_config);
		check("dll", 16'h1, dll_running);
		$display("test fields done");
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			i_ctrl.issue(3'h4, `DMC_BANK_MR0, r.mr0);
			tick(4);
			i_ctrl.issue(r.wr ? 3'h1 : 3'h2, 3'h0, {3'h0, r.bc, 9'h0, r.col});
			wait_burst(r.wr, n);
			if (!r.wr)
				check("latency", 16'h2, n);
			ws = 15;
			for (int k = 0; k < 8; k++) begin
				if (k < r.beats)
					check("word", ew(r.col, k, r.mr0[3], r.wr, r.beats == 4),
						word_index);
				check("dq_oe", !r.wr && k < r.beats, dq_oe);
				check("odt", r.wr && k < r.beats, odt_wr_apply);
				if (write_start === 1'b1)
					ws = k;
				tick(1);
			end
			if (r.wr)
				check("wstart", r.mr0[1] ? 5 : 7, ws);
		end
		$display("test bursts done");
		i_ctrl.issue(3'h4, `DMC_BANK_MR0, 16'h1a34);
		tick(4);
		pd_precharge <= 1'b1;
		tick(4);
		check("dll_pd_fast", 16'h1, dll_running);
		pd_precharge <= 1'b0;
		i_ctrl.issue(3'h4, `DMC_BANK_MR0, 16'h0a34);
		tick(4);
		pd_precharge <= 1'b1;
		tick(4);
		check("dll_pd_slow", 16'h0, dll_running);
		pd_precharge <= 1'b0;
		self_refresh <= 1'b1;
		tick(4);
		check("dll_sr", 16'h0, dll_running);
		self_refresh <= 1'b0;
		tick(12);
		check("dll_back", 16'h1, dll_running);
		$display("test dll done");
		// raw cl code 2 with al code 1 holds the read one extra cycle
		i_ctrl.issue(3'h4, `DMC_BANK_MR1, 16'h0008);
		i_ctrl.issue(3'h4, `DMC_BANK_MR0, 16'h0010);
		tick(4);
		i_ctrl.issue(3'h2, 3'h0, 16'h1000);
		wait_burst(1'b0, n);
		check("al_latency", 16'h3, n);
		check("al", 16'h1, additive_latency);
		tick(12);
		i_ctrl.issue(3'h4, `DMC_BANK_MR1, 16'h1000);
		tick(4);
		i_ctrl.issue(3'h2, 3'h0, 16'h1000);
		wait_burst(1'b0, n);
		check("qoff", 16'd20, n);
		$display("test latency done");
		finish_test();
	end
endmodule // ddr3_mode_burst_dll_config_tb
